//--- logic/epc_defines.svh
// offsets, field positions, reset values and timing counts of the program control block
`ifndef EPC_DEFINES_SVH
`define EPC_DEFINES_SVH

// register offsets on the plain register port
`define EPC_CTRL_OFS 8'h1c
`define EPC_STAT_OFS 8'h1d
`define EPC_OPT1_OFS 8'h1e
`define EPC_OPT2_OFS 8'h1f

// control register fields and reset value
`define EPC_CTRL_PWR_BIT 0
`define EPC_CTRL_LAT_BIT 2
`define EPC_CTRL_RESET 8'h00

// status register fields
`define EPC_STAT_VPASS_BIT 0
`define EPC_STAT_DONE_BIT 1
`define EPC_STAT_MODE_LO 2
`define EPC_STAT_EXT_BIT 4

// option byte locations inside the array
`define EPC_OPT1_ADDR 13'h1f00
`define EPC_OPT2_ADDR 13'h1eff
`define EPC_OPT_RESET 8'h00

// timing: least programming pulse, clock period, derived least cycle count
`define EPC_PULSE_NS 4000000
`define EPC_CLK_NS 20
`define EPC_PULSE_CYCLES ((`EPC_PULSE_NS + `EPC_CLK_NS - 1) / `EPC_CLK_NS)

`endif

//--- logic/epc_pkg.sv
// types shared by the program control block
package epc_pkg;

  typedef logic [7:0] epc_byte_t;
  typedef logic [12:0] epc_addr_t;

  typedef enum logic [1:0] {
    EPC_MODE_NONE,
    EPC_MODE_PROG_VERIFY,
    EPC_MODE_VERIFY,
    EPC_MODE_DUMP
  } epc_boot_mode_e;

  typedef enum logic [1:0] {
    EPC_OPT_LOAD1,
    EPC_OPT_LOAD2,
    EPC_OPT_RUN
  } epc_opt_state_e;

endpackage

//--- logic/epc_mode_decode.sv
// bootloader mode selection from the port c strap pins
`timescale 1ns/1ps
module epc_mode_decode (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic port_c_bit3,
  input wire logic port_c_bit4,
  input wire logic port_c_bit5,
  input wire logic port_c_bit6,
  output epc_pkg::epc_boot_mode_e boot_mode,
  output logic ext_copy
);
  import epc_pkg::*;

  epc_boot_mode_e mode_reg, mode_next;
  logic ext_reg, ext_next;

  always_comb begin
    case ({port_c_bit6, port_c_bit4, port_c_bit3})
      3'h7: mode_next = EPC_MODE_PROG_VERIFY;
      3'h6: mode_next = EPC_MODE_VERIFY;
      3'h4: mode_next = EPC_MODE_DUMP;
      default: mode_next = EPC_MODE_NONE;
    endcase
    // grounded bit 5 marks the external copy fixture
    ext_next = ~port_c_bit5;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= EPC_MODE_NONE;
      ext_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      ext_reg <= ext_next;
    end
  end

  assign boot_mode = mode_reg;
  assign ext_copy = ext_reg;

endmodule

//--- logic/epc_array.sv
// nonvolatile byte array with programming pulse timer
`timescale 1ns/1ps
module epc_array #(
  parameter int unsigned PULSE_CYCLES = 200000,
  parameter int unsigned DEPTH = 8192,
  parameter int unsigned AW = 13,
  parameter int unsigned DW = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic prog_power,
  input wire logic [AW-1:0] prog_addr,
  input wire logic [DW-1:0] prog_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data,
  output logic pulse_done
);
  // erased cells read as zero
  logic [DW-1:0] mem [DEPTH] = '{default: '0};
  logic [31:0] cnt_reg, cnt_next;
  logic done_reg, done_next;
  logic commit;

  always_comb begin
    cnt_next = cnt_reg;
    done_next = done_reg;
    commit = 1'b0;
    if (!prog_power) begin
      cnt_next = 32'h0;
      done_next = 1'b0;
    end else if (!done_reg) begin
      cnt_next = cnt_reg + 32'h1;
      if (cnt_reg == PULSE_CYCLES - 1) begin
        commit = 1'b1;
        done_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 32'h0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  // programming can only set bits; erasing is outside the chip
  always_ff @(posedge clk) begin
    if (commit) begin
      mem[prog_addr] <= mem[prog_addr] | prog_data;
    end
  end

  assign rd_data = mem[rd_addr];
  assign pulse_done = done_reg;

endmodule

//--- logic/epc_top.sv
// program memory control: control register, latch path, option load, bootloader straps
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "epc_defines.svh"
module epc_top #(
  parameter int unsigned PULSE_CYCLES = `EPC_PULSE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [12:0] arr_addr,
  input wire logic [7:0] arr_wdata,
  input wire logic arr_wr,
  input wire logic arr_rd,
  output logic [7:0] arr_rdata,
  input wire logic port_c_bit3,
  input wire logic port_c_bit4,
  input wire logic port_c_bit5,
  input wire logic port_c_bit6,
  output logic program_power_bit,
  output logic latch_enable_bit,
  output logic prog_led,
  output logic verify_led,
  output epc_pkg::epc_byte_t option_fuse_bytes_1,
  output epc_pkg::epc_byte_t option_fuse_bytes_2
);
  import epc_pkg::*;

  localparam epc_byte_t CTRL_RESET_VAL = `EPC_CTRL_RESET;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic [1:0] rst_sync_reg;
  logic rst_n_int;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n_int = rst_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // submodules
  epc_boot_mode_e boot_mode;
  logic ext_copy;
  epc_addr_t rd_addr;
  epc_byte_t rd_data;
  epc_addr_t tgt_addr_reg, tgt_addr_next;
  epc_byte_t tgt_data_reg, tgt_data_next;
  logic pwr_reg, pwr_next;
  logic lat_reg, lat_next;
  logic pulse_done;

  epc_mode_decode u_mode (
    .clk(clk),
    .rst_n(rst_n_int),
    .port_c_bit3(port_c_bit3),
    .port_c_bit4(port_c_bit4),
    .port_c_bit5(port_c_bit5),
    .port_c_bit6(port_c_bit6),
    .boot_mode(boot_mode),
    .ext_copy(ext_copy)
  );

  epc_array #(
    .PULSE_CYCLES(PULSE_CYCLES)
  ) u_array (
    .clk(clk),
    .rst_n(rst_n_int),
    .prog_power(pwr_reg),
    .prog_addr(tgt_addr_reg),
    .prog_data(tgt_data_reg),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .pulse_done(pulse_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control register and programming target
  logic ctrl_wr;
  logic cap_reg, cap_next;
  logic vpass_reg, vpass_next;
  logic verify_mode;

  assign ctrl_wr = reg_wr && (reg_addr == `EPC_CTRL_OFS);
  assign verify_mode = (boot_mode == EPC_MODE_PROG_VERIFY) || (boot_mode == EPC_MODE_VERIFY);

  always_comb begin
    lat_next = lat_reg;
    pwr_next = pwr_reg;
    cap_next = cap_reg;
    tgt_addr_next = tgt_addr_reg;
    tgt_data_next = tgt_data_reg;
    vpass_next = vpass_reg;
    if (ctrl_wr) begin
      lat_next = reg_wdata[`EPC_CTRL_LAT_BIT];
      pwr_next = reg_wdata[`EPC_CTRL_PWR_BIT] & lat_reg;
      if (!reg_wdata[`EPC_CTRL_LAT_BIT]) begin
        pwr_next = 1'b0;
      end
    end
    if (!lat_reg) begin
      cap_next = 1'b0;
    end else if (arr_wr && !cap_reg) begin
      cap_next = 1'b1;
      tgt_addr_next = arr_addr;
      tgt_data_next = arr_wdata;
    end
    // verify result only meaningful in a verify mode
    if (reg_wr && (reg_addr == `EPC_STAT_OFS)) begin
      vpass_next = reg_wdata[`EPC_STAT_VPASS_BIT] & verify_mode;
    end
  end

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      lat_reg <= CTRL_RESET_VAL[`EPC_CTRL_LAT_BIT];
      pwr_reg <= CTRL_RESET_VAL[`EPC_CTRL_PWR_BIT];
      cap_reg <= 1'b0;
      tgt_addr_reg <= 13'h0;
      tgt_data_reg <= 8'h0;
      vpass_reg <= 1'b0;
    end else begin
      lat_reg <= lat_next;
      pwr_reg <= pwr_next;
      cap_reg <= cap_next;
      tgt_addr_reg <= tgt_addr_next;
      tgt_data_reg <= tgt_data_next;
      vpass_reg <= vpass_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // option byte load after reset
  epc_opt_state_e opt_state_reg, opt_state_next;
  epc_byte_t opt1_reg, opt1_next;
  epc_byte_t opt2_reg, opt2_next;

  // options taken only on reset exit
  always_comb begin
    opt_state_next = opt_state_reg;
    opt1_next = opt1_reg;
    opt2_next = opt2_reg;
    case (opt_state_reg)
      EPC_OPT_LOAD1: begin
        opt1_next = rd_data;
        opt_state_next = EPC_OPT_LOAD2;
      end
      EPC_OPT_LOAD2: begin
        opt2_next = rd_data;
        opt_state_next = EPC_OPT_RUN;
      end
      EPC_OPT_RUN: begin
        opt_state_next = EPC_OPT_RUN;
      end
      default: begin
        opt_state_next = EPC_OPT_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      opt_state_reg <= EPC_OPT_LOAD1;
      opt1_reg <= `EPC_OPT_RESET;
      opt2_reg <= `EPC_OPT_RESET;
    end else begin
      opt_state_reg <= opt_state_next;
      opt1_reg <= opt1_next;
      opt2_reg <= opt2_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array read path and register reads
  epc_byte_t arr_rdata_reg, arr_rdata_next;
  epc_byte_t reg_rdata_reg, reg_rdata_next;
  logic led_p_reg, led_p_next;

  always_comb begin
    if (opt_state_reg == EPC_OPT_LOAD1) begin
      rd_addr = `EPC_OPT1_ADDR;
    end else if (opt_state_reg == EPC_OPT_LOAD2) begin
      rd_addr = `EPC_OPT2_ADDR;
    end else if (lat_reg) begin
      rd_addr = tgt_addr_reg;
    end else begin
      rd_addr = arr_addr;
    end
  end

  always_comb begin
    arr_rdata_next = 8'h0;
    if (arr_rd && !lat_reg && (opt_state_reg == EPC_OPT_RUN)) begin
      arr_rdata_next = rd_data;
    end
    reg_rdata_next = 8'h0;
    if (reg_rd) begin
      case (reg_addr)
        `EPC_CTRL_OFS: begin
          reg_rdata_next[`EPC_CTRL_LAT_BIT] = lat_reg;
          reg_rdata_next[`EPC_CTRL_PWR_BIT] = pwr_reg;
        end
        `EPC_STAT_OFS: begin
          reg_rdata_next[`EPC_STAT_VPASS_BIT] = vpass_reg;
          reg_rdata_next[`EPC_STAT_DONE_BIT] = pulse_done;
          reg_rdata_next[`EPC_STAT_MODE_LO +: 2] = boot_mode;
          reg_rdata_next[`EPC_STAT_EXT_BIT] = ext_copy;
        end
        `EPC_OPT1_OFS: reg_rdata_next = opt1_reg;
        `EPC_OPT2_OFS: reg_rdata_next = opt2_reg;
        default: reg_rdata_next = 8'h0;
      endcase
    end
    led_p_next = pwr_next;
  end

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      arr_rdata_reg <= 8'h0;
      reg_rdata_reg <= 8'h0;
      led_p_reg <= 1'b0;
    end else begin
      arr_rdata_reg <= arr_rdata_next;
      reg_rdata_reg <= reg_rdata_next;
      led_p_reg <= led_p_next;
    end
  end

  // power pin straight from the bit
  assign program_power_bit = pwr_reg;
  assign latch_enable_bit = lat_reg;
  assign prog_led = led_p_reg;
  assign verify_led = vpass_reg;
  assign reg_rdata = reg_rdata_reg;
  assign arr_rdata = arr_rdata_reg;
  assign option_fuse_bytes_1 = opt1_reg;
  assign option_fuse_bytes_2 = opt2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_int);

  property p_power_off;
    ctrl_wr && !reg_wdata[`EPC_CTRL_PWR_BIT] |=> !program_power_bit;
  endproperty
  a_power_off: assert property (p_power_off) else $error("power stayed on");

  property p_power_needs_latch;
    program_power_bit |-> latch_enable_bit && $past(latch_enable_bit);
  endproperty
  a_power_needs_latch: assert property (p_power_needs_latch) else $error("power without latch");

  property p_latch_drop;
    ctrl_wr && !reg_wdata[`EPC_CTRL_LAT_BIT] |=> !latch_enable_bit && !program_power_bit;
  endproperty
  a_latch_drop: assert property (p_latch_drop) else $error("latch clear left power");

  property p_both_set;
    ctrl_wr && !latch_enable_bit && reg_wdata[`EPC_CTRL_LAT_BIT] && reg_wdata[`EPC_CTRL_PWR_BIT]
      |=> latch_enable_bit && !program_power_bit;
  endproperty
  a_both_set: assert property (p_both_set) else $error("both bits set at once");

  property p_power_set;
    ctrl_wr && latch_enable_bit && (reg_wdata[2:0] == 3'h5) |=> program_power_bit;
  endproperty
  a_power_set: assert property (p_power_set) else $error("power set refused");

  property p_ctrl_read;
    reg_rd && (reg_addr == `EPC_CTRL_OFS)
      |=> reg_rdata == {5'h0, $past(latch_enable_bit), 1'b0, $past(program_power_bit)};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");

  property p_read_blocked;
    arr_rd && latch_enable_bit |=> arr_rdata == 8'h0;
  endproperty
  a_read_blocked: assert property (p_read_blocked) else $error("latched array read data");

  property p_capture;
    arr_wr && lat_reg && !cap_reg |=> tgt_addr_reg == $past(arr_addr) && cap_reg;
  endproperty
  a_capture: assert property (p_capture) else $error("target not captured");

  property p_led;
    prog_led == program_power_bit;
  endproperty
  a_led: assert property (p_led) else $error("program indicator wrong");

  property p_mode;
    port_c_bit6 && port_c_bit4 && !port_c_bit3 [*2] |-> boot_mode == EPC_MODE_VERIFY;
  endproperty
  a_mode: assert property (p_mode) else $error("verify mode not decoded");

  property p_opt_hold;
    opt_state_reg == EPC_OPT_RUN |=> $stable(option_fuse_bytes_1) && $stable(option_fuse_bytes_2);
  endproperty
  a_opt_hold: assert property (p_opt_hold) else $error("options changed after load");

  c_program: cover property (ctrl_wr && latch_enable_bit && reg_wdata[`EPC_CTRL_PWR_BIT] ##1
    program_power_bit);
  c_both: cover property (ctrl_wr && reg_wdata[2:0] == 3'h5 && !latch_enable_bit);
  c_capture: cover property (arr_wr && lat_reg && !cap_reg);
  c_verify_led: cover property (verify_led);

endmodule

//--- sim/epc_fixture.sv
// strap fixture model: drives the bootloader select pins of port c
`timescale 1ns/1ps
module epc_fixture (
  input wire logic clk,
  input wire logic cnt_clr,
  input wire logic cnt_step,
  input wire logic hi_page,
  input wire logic [2:0] sel,
  input wire logic ext_copy,
  output logic [12:0] src_addr,
  output logic port_c_bit3,
  output logic port_c_bit4,
  output logic port_c_bit5,
  output logic port_c_bit6
);
  logic [11:0] cnt_reg;

  // 12-bit source counter, page pin on top
  always_ff @(posedge clk) begin
    if (cnt_clr) begin
      cnt_reg <= 12'h000;
    end else if (cnt_step) begin
      cnt_reg <= cnt_reg + 12'h001;
    end
  end
  assign src_addr = {hi_page, cnt_reg};

  // select on pins 6, 4, 3
  assign {port_c_bit6, port_c_bit4, port_c_bit3} = sel;
  assign port_c_bit5 = ~ext_copy;
endmodule

//--- sim/eprom_program_control_bench.sv
// self-checking bench for the program control block
`timescale 1ns/1ps
`include "epc_defines.svh"
module eprom_program_control_bench;
  import epc_pkg::*;
  localparam int PULSE = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, arr_wdata = 8'h00;
  logic [7:0] reg_rdata, arr_rdata, rv, ctl, v;
  logic [12:0] arr_addr = 13'h0000, a;
  logic reg_wr = 1'b0, reg_rd = 1'b0, arr_wr = 1'b0, arr_rd = 1'b0, ext = 1'b0;
  logic [2:0] sel = 3'h0;
  logic cnt_clr = 1'b0, cnt_step = 1'b0, hi = 1'b0;
  logic [12:0] src;
  logic b3, b4, b5, b6, pwr, lat, pled, vled;
  epc_byte_t opt1, opt2;
  int fail_count = 0;
  int checks = 0;

  epc_top #(.PULSE_CYCLES(PULSE)) dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_wr(arr_wr), .arr_rd(arr_rd),
    .arr_rdata(arr_rdata), .port_c_bit3(b3), .port_c_bit4(b4), .port_c_bit5(b5),
    .port_c_bit6(b6), .program_power_bit(pwr), .latch_enable_bit(lat), .prog_led(pled),
    .verify_led(vled), .option_fuse_bytes_1(opt1), .option_fuse_bytes_2(opt2));
  epc_fixture fix (.clk(clk), .cnt_clr(cnt_clr), .cnt_step(cnt_step), .hi_page(hi),
    .sel(sel), .ext_copy(ext), .src_addr(src), .port_c_bit3(b3), .port_c_bit4(b4),
    .port_c_bit5(b5), .port_c_bit6(b6));

  initial begin
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic rwr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rrd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic awr(input logic [12:0] ad, input logic [7:0] d);
    @(posedge clk);
    arr_addr <= ad;
    arr_wdata <= d;
    arr_wr <= 1'b1;
    @(posedge clk);
    arr_wr <= 1'b0;
  endtask

  task automatic ard(input logic [12:0] ad, output logic [7:0] d);
    @(posedge clk);
    arr_addr <= ad;
    arr_rd <= 1'b1;
    @(posedge clk);
    arr_rd <= 1'b0;
    #1 d = arr_rdata;
  endtask

  // source address from fixture counter and page pin
  task automatic src_at(input logic h, input int n);
    @(posedge clk);
    hi <= h;
    cnt_clr <= 1'b1;
    @(posedge clk);
    cnt_clr <= 1'b0;
    cnt_step <= 1'b1;
    repeat (n) @(posedge clk);
    cnt_step <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [7:0] next_ctl(input logic [7:0] old, input logic [7:0] d);
    next_ctl = {5'h00, d[2], 1'b0, d[0] & d[2] & old[2]};
  endfunction

  function automatic logic [1:0] mode_of(input logic [2:0] s);
    case (s)
      3'b111: mode_of = EPC_MODE_PROG_VERIFY;
      3'b110: mode_of = EPC_MODE_VERIFY;
      3'b100: mode_of = EPC_MODE_DUMP;
      default: mode_of = EPC_MODE_NONE;
    endcase
  endfunction

  task automatic cwr(input logic [7:0] d);
    ctl = next_ctl(ctl, d);
    rwr(`EPC_CTRL_OFS, d);
    rrd(`EPC_CTRL_OFS, rv);
    check(rv, ctl);
    check({5'h00, lat, 1'b0, pwr}, ctl);
    check({7'h00, pled}, {7'h00, ctl[0]});
  endtask

  task automatic prog(input logic [12:0] ad, input logic [7:0] d);
    cwr(8'h04);
    awr(ad, d);
    awr(ad ^ 13'h0001, ~d);
    ard(ad, rv);
    check(rv, 8'h00);
    cwr(8'h05);
    repeat (PULSE + 2) @(posedge clk);
    rrd(`EPC_STAT_OFS, rv);
    check({7'h00, rv[1]}, 8'h01);
    cwr(8'h00);
    rrd(`EPC_STAT_OFS, rv);
    check({7'h00, rv[1]}, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    summarize();
  end

  initial begin
    void'($urandom(76062));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    ctl = 8'h00;
    rrd(`EPC_CTRL_OFS, rv);
    check(rv, 8'h00);
    rrd(8'h40, rv);
    check(rv, 8'h00);
    // corner cases before the random mix
    cwr(8'h05);
    cwr(8'h05);
    cwr(8'h01);
    cwr(8'h01);
    cwr(8'hff);
    for (int i = 0; i < 12; i++) begin
      cwr(8'($urandom));
    end
    cwr(8'h00);
    // main code at the same addresses as the target
    src_at(1'b0, 256 + int'($urandom_range(0, 63)));
    a = src & 13'h1ffe;
    v = 8'($urandom_range(1, 255));
    prog(a, v);
    ard(a, rv);
    check(rv, v);
    ard(a ^ 13'h0001, rv);
    check(rv, 8'h00);
    // option byte must wait for the next reset
    v = 8'($urandom_range(1, 255));
    // option byte at its own address, upper page selected
    src_at(1'b1, 3840);
    check(src[7:0], 8'h00);
    check({3'h0, src[12:8]}, 8'h1f);
    prog(src, v);
    check(opt1, 8'h00);
    // reset reasserted, then released to restart
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    ctl = 8'h00;
    check(opt1, v);
    check(opt2, 8'h00);
    rrd(`EPC_CTRL_OFS, rv);
    check(rv, 8'h00);
    rrd(`EPC_OPT1_OFS, rv);
    check(rv, v);
    rrd(`EPC_OPT2_OFS, rv);
    check(rv, 8'h00);
    // every strap code, with and without the copy setup
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      sel <= i[2:0];
      ext <= i[3];
      repeat (3) @(posedge clk);
      rrd(`EPC_STAT_OFS, rv);
      check({5'h00, rv[4:2]}, {5'h00, i[3], mode_of(i[2:0])});
      // verify pass only sticks in a verify mode
      rwr(`EPC_STAT_OFS, 8'h01);
      rrd(`EPC_STAT_OFS, rv);
      check({7'h00, vled}, {7'h00, (i[2:1] == 2'h3)});
      check({7'h00, rv[0]}, {7'h00, (i[2:1] == 2'h3)});
    end
    summarize();
  end
endmodule
